// ===== user_var_arith_unit_tb.sv
// Self-checking bench for the user variable arithmetic unit.
// Assumes the host model and a 250 MHz clock; inputs move 1 ns late.
`timescale 1ns/1ns
`default_nettype none
module user_var_arith_unit_tb
  import uvau_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_cmd_valid, i_direct, o_ready, o_done, o_reply_valid;
  logic [7:0]  i_opcode, i_type, i_index, o_reply_status;
  logic [7:0]  i_rd_index = 8'h00;
  logic [31:0] i_value, o_reply_value, o_x, o_rd_data;
  logic        o_flag_zero, o_flag_eq, o_flag_gt, o_flag_lt;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [31:0] d;
  localparam logic [31:0] A = 32'hfffe_0c1f;
  localparam logic [31:0] B = 32'h0000_1234;

  ////////////////////////////////////////////////////////////////////////
  // Clock, unit and host
  always #2 i_mclk = ~i_mclk;

  uvau_top uut (.i_mclk, .i_rst_n, .i_cmd_valid, .i_opcode, .i_type,
    .i_index, .i_value, .i_direct, .i_rd_index, .o_ready, .o_done,
    .o_reply_valid, .o_reply_status, .o_reply_value, .o_x, .o_rd_data,
    .o_flag_zero, .o_flag_eq, .o_flag_gt, .o_flag_lt);

  uvau_host host (.i_mclk(i_mclk), .i_ready(o_ready),
    .o_cmd_valid(i_cmd_valid), .o_opcode(i_opcode), .o_type(i_type),
    .o_index(i_index), .o_value(i_value), .o_direct(i_direct));

  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and expected results
  task automatic cmp(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] calc(input logic [7:0] t,
                                       input logic [31:0] a, b);
    case (t)
      T_ADD: return a + b;
      T_SUB: return a - b;
      T_MUL: return a * b;
      T_DIV: return $signed(a) / $signed(b);
      T_MOD: return $signed(a) % $signed(b);
      T_AND: return a & b;
      T_OR: return a | b;
      T_XOR: return a ^ b;
      T_NOT: return ~b;
      default: return b;
    endcase
  endfunction

  // One command through to its done pulse, reply judged
  task automatic run(input logic [7:0] op, ty, idx,
                     input logic [31:0] v, input logic dir);
    int n;
    host.issue(op, ty, idx, v, dir);
    cmp("busy", 32'h0, {31'h0, o_ready});
    n = 0;
    while (o_done !== 1'b1 && n < 40) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    cmp("done", 32'h1, {31'h0, o_done});
    cmp("ready", 32'h1, {31'h0, o_ready});
    cmp("reply_valid", {31'h0, dir}, {31'h0, o_reply_valid});
    cmp("status", 32'(STATUS_OK), {24'h0, o_reply_status});
    cmp("reply_value", v, o_reply_value);
  endtask

  task automatic rdv(input logic [7:0] idx, output logic [31:0] q);
    i_rd_index = idx;
    @(posedge i_mclk);
    #1;
    q = o_rd_data;
  endtask

  function automatic logic [31:0] flags();
    return {28'h0, o_flag_lt, o_flag_gt, o_flag_eq, o_flag_zero};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_vx;
    run(OPC_VI, T_LOAD, 8'h05, B, 1'b1);
    run(OPC_XV, T_LOAD, 8'h05, 32'h0, 1'b1);
    for (int t = 0; t < 10; t++) begin
      run(OPC_VI, T_LOAD, 8'hff, A, 1'b0);
      run(OPC_VX, t[7:0], 8'hff, 32'h0, 1'b1);
      rdv(8'hff, d);
      cmp("var_vx", calc(t[7:0], A, B), d);
      cmp("x_vx", B, o_x);
    end
  endtask

  task automatic t_xv;
    run(OPC_VI, T_LOAD, 8'h1b, A, 1'b1);
    for (int t = 0; t < 10; t++) begin
      run(OPC_XV, T_LOAD, 8'h05, 32'h0, 1'b0);
      run(OPC_XV, t[7:0], 8'h1b, 32'h0, 1'b1);
      cmp("x_xv", calc(t[7:0], B, A), o_x);
      rdv(8'h1b, d);
      cmp("var_xv", A, d);
    end
  endtask

  task automatic t_vi;
    logic [31:0] e;
    for (int t = 0; t < 10; t++) begin
      run(OPC_VI, T_LOAD, 8'h00, A, 1'b0);
      run(OPC_VI, t[7:0], 8'h00, B, 1'b1);
      rdv(8'h00, d);
      e = (t == 8) ? ~A : calc(t[7:0], A, B);
      cmp("var_vi", e, d);
    end
  endtask

  task automatic t_swap_undef;
    run(OPC_XV, T_LOAD, 8'h05, 32'h0, 1'b1);
    run(OPC_VX, T_SWAP, 8'h1b, 32'h0, 1'b1);
    rdv(8'h1b, d);
    cmp("swap_var", B, d);
    cmp("swap_x", A, o_x);
    run(OPC_XV, T_SWAP, 8'h1b, 32'h0, 1'b1);
    rdv(8'h1b, d);
    cmp("swap2_var", A, d);
    cmp("swap2_x", B, o_x);
    run(OPC_VI, T_SWAP, 8'h1b, B, 1'b1);
    run(OPC_VI, 8'h0c, 8'h1b, B, 1'b1);
    run(OPC_VI, 8'hff, 8'h1b, B, 1'b1);
    rdv(8'h1b, d);
    cmp("undef_var", A, d);
    cmp("undef_x", B, o_x);
  endtask

  task automatic t_div_zero;
    run(OPC_VI, T_LOAD, 8'h06, 32'h0, 1'b1);
    run(OPC_XV, T_DIV, 8'h06, 32'h0, 1'b1);
    run(OPC_XV, T_MOD, 8'h06, 32'h0, 1'b1);
    cmp("x_div0", B, o_x);
    run(OPC_VI, T_DIV, 8'h1b, 32'h0, 1'b1);
    run(OPC_VI, T_MOD, 8'h1b, 32'h0, 1'b1);
    run(OPC_XV, T_LOAD, 8'h06, 32'h0, 1'b1);
    run(OPC_VX, T_DIV, 8'h1b, 32'h0, 1'b1);
    run(OPC_VX, T_MOD, 8'h1b, 32'h0, 1'b1);
    rdv(8'h1b, d);
    cmp("var_div0", A, d);
    run(OPC_XV, T_LOAD, 8'h05, 32'h0, 1'b1);
  endtask

  // An opcode outside the three is never taken: no done, still ready
  task automatic t_refuse;
    host.issue(8'h2e, T_LOAD, 8'h1b, B, 1'b1);
    repeat (3) begin
      cmp("refused_done", 32'h0, {31'h0, o_done});
      cmp("refused_ready", 32'h1, {31'h0, o_ready});
      @(posedge i_mclk);
      #1;
    end
    rdv(8'h1b, d);
    cmp("refused_var", A, d);
  endtask

  task automatic t_compare;
    run(OPC_VX, T_COMP, 8'h1b, 32'h0, 1'b1);
    cmp("flags_vx", 32'h8, flags());
    rdv(8'h1b, d);
    cmp("cmp_var", A, d);
    cmp("cmp_x", B, o_x);
    run(OPC_XV, T_COMP, 8'h1b, 32'h0, 1'b1);
    cmp("flags_xv", 32'h4, flags());
    cmp("cmp_x2", B, o_x);
    run(OPC_VI, T_COMP, 8'h1b, A, 1'b1);
    cmp("flags_vi", 32'h3, flags());
    run(OPC_VX, T_COMP, 8'h1b, 32'h0, 1'b0);
    run(OPC_VI, T_LOAD, 8'h1c, 32'h0, 1'b0);
    cmp("flags_zero", 32'h9, flags());
    run(OPC_VI, T_LOAD, 8'h1c, 32'h1, 1'b0);
    cmp("flags_nz", 32'h8, flags());
    run(OPC_VX, T_SWAP, 8'h1b, 32'h0, 1'b0);
    cmp("flags_swap", 32'h8, flags());
    rdv(8'h1b, d);
    cmp("cmp_var2", B, d);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge i_mclk);
    #1;
    cmp("rst_ready", 32'h0, {31'h0, o_ready});
    cmp("rst_x", 32'h0, o_x);
    cmp("rst_flags", 32'h0, flags());
    i_rst_n = 1'b1;
    t_vx();
    t_xv();
    t_vi();
    t_swap_undef();
    t_div_zero();
    t_refuse();
    t_compare();
    report_and_stop();
  end

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== uvau_div.sv
// Signed 32-bit serial divider, one quotient bit per clock.
// Latches both operands on i_start; assumes the caller never
// starts with a zero divisor.
`timescale 1ns/1ns
`default_nettype none
module uvau_div
  import uvau_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [31:0] i_dvd,
  input  wire logic [31:0] i_dvs,
  output logic             o_done,
  output logic [31:0]      o_quot,
  output logic [31:0]      o_rem
);

  logic [5:0]  cnt_ff, nxt_cnt;
  logic [31:0] q_ff, nxt_q;
  logic [31:0] r_ff, nxt_r;
  logic [31:0] d_ff, nxt_d;
  logic        qneg_ff, nxt_qneg;
  logic        rneg_ff, nxt_rneg;
  logic        done_ff, nxt_done;
  logic [32:0] part;
  logic [32:0] trial;

  //////////////////////////////////////////////////////////////////////////
  // Restoring division on magnitudes, signs fixed at the output
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_q    = q_ff;
    nxt_r    = r_ff;
    nxt_d    = d_ff;
    nxt_qneg = qneg_ff;
    nxt_rneg = rneg_ff;
    nxt_done = 1'b0;
    part     = {r_ff, q_ff[31]};
    trial    = part - {1'b0, d_ff};
    if (i_start) begin
      nxt_cnt  = DIV_STEPS;
      nxt_q    = i_dvd[31] ? -i_dvd : i_dvd;
      nxt_d    = i_dvs[31] ? -i_dvs : i_dvs;
      nxt_r    = '0;
      nxt_qneg = i_dvd[31] ^ i_dvs[31];
      nxt_rneg = i_dvd[31]; // Remainder takes the dividend's sign
    end else if (cnt_ff != 6'h00) begin
      if (!trial[32]) begin
        nxt_r = trial[31:0];
        nxt_q = {q_ff[30:0], 1'b1};
      end else begin
        nxt_r = part[31:0];
        nxt_q = {q_ff[30:0], 1'b0};
      end
      nxt_cnt  = cnt_ff - 6'h01;
      nxt_done = (cnt_ff == 6'h01);
    end
  end

  // State registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_ff  <= 6'h00;
      q_ff    <= '0;
      r_ff    <= '0;
      d_ff    <= '0;
      qneg_ff <= 1'b0;
      rneg_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      q_ff    <= nxt_q;
      r_ff    <= nxt_r;
      d_ff    <= nxt_d;
      qneg_ff <= nxt_qneg;
      rneg_ff <= nxt_rneg;
      done_ff <= nxt_done;
    end
  end

  assign o_done = done_ff;
  assign o_quot = qneg_ff ? -q_ff : q_ff;
  assign o_rem  = rneg_ff ? -r_ff : r_ff;

endmodule
`default_nettype wire

// ===== uvau_host.sv
// Host model presenting calculation commands to the arithmetic unit.
// Assumes the caller enters issue 1 ns after a rising edge of i_mclk.
`timescale 1ns/1ns
`default_nettype none
module uvau_host
  import uvau_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_ready,
  output logic             o_cmd_valid,
  output logic [7:0]       o_opcode,
  output logic [7:0]       o_type,
  output logic [7:0]       o_index,
  output logic [31:0]      o_value,
  output logic             o_direct
);
  ////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_opcode    = 8'h00;
    o_type      = 8'h00;
    o_index     = 8'h00;
    o_value     = 32'h0000_0000;
    o_direct    = 1'b0;
  end

  // Wait for ready, hold the command over the taking edge, then release
  task automatic issue(input logic [7:0] op, ty, idx,
                       input logic [31:0] val, input logic dir);
    int n;
    n = 0;
    while (i_ready !== 1'b1 && n < 50) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    o_cmd_valid = 1'b1;
    o_opcode    = op;
    o_type      = ty;
    o_index     = idx;
    o_value     = val;
    o_direct    = dir;
    @(posedge i_mclk);
    #1;
    // Released fields show the inverse so stale values cannot pass
    o_cmd_valid = 1'b0;
    o_opcode    = ~o_opcode;
    o_type      = ~o_type;
    o_index     = ~o_index;
    o_value     = ~o_value;
    o_direct    = ~o_direct;
  endtask
endmodule
`default_nettype wire

// ===== uvau_pkg.sv
// Constants and types shared by the user variable arithmetic unit.
// Assumes one clock domain and a synchronous active-low reset.
package uvau_pkg;

  // Opcodes of the three calculation instructions
  localparam logic [7:0] OPC_VX = 8'h2b; // user_var_with_x_op
  localparam logic [7:0] OPC_XV = 8'h2c; // x_with_user_var_op
  localparam logic [7:0] OPC_VI = 8'h2d; // user_var_with_immediate_op

  // Operation codes carried in the type field
  localparam logic [7:0] T_ADD  = 8'h00;
  localparam logic [7:0] T_SUB  = 8'h01;
  localparam logic [7:0] T_MUL  = 8'h02; // multiply_operation
  localparam logic [7:0] T_DIV  = 8'h03;
  localparam logic [7:0] T_MOD  = 8'h04; // remainder_operation
  localparam logic [7:0] T_AND  = 8'h05;
  localparam logic [7:0] T_OR   = 8'h06;
  localparam logic [7:0] T_XOR  = 8'h07;
  localparam logic [7:0] T_NOT  = 8'h08;
  localparam logic [7:0] T_LOAD = 8'h09;
  localparam logic [7:0] T_SWAP = 8'h0a;
  localparam logic [7:0] T_COMP = 8'h0b;

  // Reply status for a successful command
  localparam logic [7:0] STATUS_OK = 8'h64;

  // Storage size and reset values
  localparam int          NUM_VARS = 256;
  localparam logic [31:0] VAR_RST  = 32'h0000_0000;
  localparam logic [31:0] X_RST    = 32'h0000_0000;
  localparam logic [3:0]  FLG_RST  = 4'h0;

  // Flag bit positions
  localparam int FLG_ZERO = 0;
  localparam int FLG_EQ   = 1;
  localparam int FLG_GT   = 2;
  localparam int FLG_LT   = 3;

  // Divider iterations, one quotient bit per cycle
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_DIV} uvau_state_t;

endpackage

// ===== uvau_top.sv
// User variable arithmetic unit: 256 user variables, the X register
// and the comparison flags, driven by three calculation instructions.
// Assumes commands come from logic on i_mclk; one command at a time.
`timescale 1ns/1ns
`default_nettype none
module uvau_top
  import uvau_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [7:0]  i_type,
  input  wire logic [7:0]  i_index,
  input  wire logic [31:0] i_value,
  input  wire logic        i_direct,
  input  wire logic [7:0]  i_rd_index,
  output logic             o_ready,
  output logic             o_done,
  output logic             o_reply_valid,
  output logic [7:0]       o_reply_status,
  output logic [31:0]      o_reply_value,
  output logic [31:0]      o_x,
  output logic [31:0]      o_rd_data,
  output logic             o_flag_zero,
  output logic             o_flag_eq,
  output logic             o_flag_gt,
  output logic             o_flag_lt
);

  uvau_state_t state_ff, nxt_state;
  logic [7:0]  opc_ff, nxt_opc;
  logic [7:0]  typ_ff, nxt_typ;
  logic [7:0]  idx_ff, nxt_idx;
  logic [31:0] imm_ff, nxt_imm;
  logic        dir_ff, nxt_dir;
  logic [31:0] x_ff, nxt_x;
  logic [3:0]  flg_ff, nxt_flg;
  logic        ready_ff, nxt_ready;
  logic        done_ff, nxt_done;
  logic        rvld_ff, nxt_rvld;
  logic [7:0]  rsts_ff, nxt_rsts;
  logic [31:0] rval_ff, nxt_rval;
  logic [31:0] rd_ff, nxt_rd;
  logic [31:0] mem_ff [NUM_VARS];
  logic        mem_wr;
  logic [31:0] mem_wdata;
  logic [31:0] var_val, dst, src, res;
  logic        to_x, wr_res, swap, cmp, fin, div_start;
  logic        cmd_ok, cmp_gt, cmp_lt;
  logic        div_done;
  logic [31:0] div_quot, div_rem;

  //////////////////////////////////////////////////////////////////////////
  // Operand selection from the latched command
  always_comb begin
    var_val = mem_ff[idx_ff];
    to_x    = (opc_ff == OPC_XV);
    dst     = to_x ? x_ff : var_val;
    if (opc_ff == OPC_VX) begin
      src = x_ff;
    end else if (to_x) begin
      src = var_val;
    end else begin
      src = imm_ff;
    end
    cmp_gt = $signed(dst) > $signed(src);
    cmp_lt = $signed(dst) < $signed(src);
    cmd_ok = (i_opcode == OPC_VX) || (i_opcode == OPC_XV) ||
             (i_opcode == OPC_VI);
  end

  //////////////////////////////////////////////////////////////////////////
  // Command sequencing and result computation
  always_comb begin
    nxt_state = state_ff;
    nxt_opc   = opc_ff;
    nxt_typ   = typ_ff;
    nxt_idx   = idx_ff;
    nxt_imm   = imm_ff;
    nxt_dir   = dir_ff;
    res       = '0;
    wr_res    = 1'b0;
    swap      = 1'b0;
    cmp       = 1'b0;
    fin       = 1'b0;
    div_start = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (i_cmd_valid && ready_ff && cmd_ok) begin
          nxt_opc   = i_opcode;
          nxt_typ   = i_type;
          nxt_idx   = i_index;
          nxt_imm   = i_value;
          nxt_dir   = i_direct;
          nxt_state = ST_CALC;
        end
      end
      ST_CALC: begin
        fin = 1'b1;
        case (typ_ff)
          T_ADD: begin
            res    = dst + src;
            wr_res = 1'b1;
          end
          T_SUB: begin
            res    = dst - src;
            wr_res = 1'b1;
          end
          T_MUL: begin
            res    = 32'(dst * src);   // Low word, same signed or not
            wr_res = 1'b1;
          end
          T_DIV, T_MOD: begin
            if (src != 32'h0000_0000) begin
              div_start = 1'b1;
              fin       = 1'b0;
              nxt_state = ST_DIV;
            end
          end
          T_AND: begin
            res    = dst & src;
            wr_res = 1'b1;
          end
          T_OR: begin
            res    = dst | src;
            wr_res = 1'b1;
          end
          T_XOR: begin
            res    = dst ^ src;
            wr_res = 1'b1;
          end
          T_NOT: begin
            res    = (opc_ff == OPC_VI) ? ~dst : ~src;
            wr_res = 1'b1;
          end
          T_LOAD: begin
            res    = src;
            wr_res = 1'b1;
          end
          T_SWAP: begin
            swap = (opc_ff != OPC_VI);
          end
          T_COMP: begin
            cmp = 1'b1;
          end
          default: begin
          end
        endcase
        if (fin) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          res       = (typ_ff == T_DIV) ? div_quot : div_rem;
          wr_res    = 1'b1;
          fin       = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Write-back to variables, X register and flags
  always_comb begin
    nxt_x     = x_ff;
    nxt_flg   = flg_ff;
    mem_wr    = 1'b0;
    mem_wdata = res;
    if (wr_res) begin
      nxt_flg[FLG_ZERO] = (res == 32'h0000_0000);
      if (to_x) begin
        nxt_x = res;
      end else begin
        mem_wr = 1'b1;
      end
    end
    if (swap) begin
      nxt_x     = var_val;
      mem_wr    = 1'b1;
      mem_wdata = x_ff;
    end
    if (cmp) begin
      nxt_flg[FLG_ZERO] = (dst == src);
      nxt_flg[FLG_EQ]   = (dst == src);
      nxt_flg[FLG_GT]   = cmp_gt;
      nxt_flg[FLG_LT]   = cmp_lt;
    end
    nxt_ready = (nxt_state == ST_IDLE);
    nxt_done  = fin;
    nxt_rvld  = fin && dir_ff;
    nxt_rsts  = fin ? STATUS_OK : rsts_ff;
    nxt_rval  = fin ? imm_ff : rval_ff;
    nxt_rd    = mem_ff[i_rd_index];
  end

  // Control and result registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      opc_ff   <= 8'h00;
      typ_ff   <= 8'h00;
      idx_ff   <= 8'h00;
      imm_ff   <= 32'h0000_0000;
      dir_ff   <= 1'b0;
      x_ff     <= X_RST;
      flg_ff   <= FLG_RST;
      ready_ff <= 1'b0;
      done_ff  <= 1'b0;
      rvld_ff  <= 1'b0;
      rsts_ff  <= 8'h00;
      rval_ff  <= 32'h0000_0000;
      rd_ff    <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      opc_ff   <= nxt_opc;
      typ_ff   <= nxt_typ;
      idx_ff   <= nxt_idx;
      imm_ff   <= nxt_imm;
      dir_ff   <= nxt_dir;
      x_ff     <= nxt_x;
      flg_ff   <= nxt_flg;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
      rvld_ff  <= nxt_rvld;
      rsts_ff  <= nxt_rsts;
      rval_ff  <= nxt_rval;
      rd_ff    <= nxt_rd;
    end
  end

  // User variable storage, one enable per entry
  for (genvar g = 0; g < NUM_VARS; g++) begin : g_var
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        mem_ff[g] <= VAR_RST;
      end else if (mem_wr && (idx_ff == 8'(g))) begin
        mem_ff[g] <= mem_wdata;
      end
    end
  end

  // Serial divider for divide and remainder
  uvau_div u_div (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (div_start),
    .i_dvd   (dst),
    .i_dvs   (src),
    .o_done  (div_done),
    .o_quot  (div_quot),
    .o_rem   (div_rem)
  );

  assign o_ready        = ready_ff;
  assign o_done         = done_ff;
  assign o_reply_valid  = rvld_ff;
  assign o_reply_status = rsts_ff;
  assign o_reply_value  = rval_ff;
  assign o_x            = x_ff;
  assign o_rd_data      = rd_ff;
  assign o_flag_zero    = flg_ff[FLG_ZERO];
  assign o_flag_eq      = flg_ff[FLG_EQ];
  assign o_flag_gt      = flg_ff[FLG_GT];
  assign o_flag_lt      = flg_ff[FLG_LT];

  //////////////////////////////////////////////////////////////////////////
  // Checks on the datapath and sequencing
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_vx_add;
    (state_ff == ST_CALC && opc_ff == OPC_VX && typ_ff == T_ADD) |=>
      mem_ff[idx_ff] == $past(var_val) + $past(x_ff);
  endproperty
  a_vx_add: assert property (p_vx_add)
    else $error("variable add with X wrong");

  property p_xv_sub;
    (state_ff == ST_CALC && to_x && typ_ff == T_SUB) |=>
      x_ff == $past(dst) - $past(var_val);
  endproperty
  a_xv_sub: assert property (p_xv_sub)
    else $error("X subtract variable wrong");

  property p_vx_load;
    (state_ff == ST_CALC && opc_ff == OPC_VX && typ_ff == T_LOAD) |=>
      (x_ff == $past(x_ff)) && (mem_ff[idx_ff] == $past(x_ff));
  endproperty
  a_vx_load: assert property (p_vx_load)
    else $error("load from X wrong or X changed");

  property p_swap;
    (state_ff == ST_CALC && opc_ff != OPC_VI && typ_ff == T_SWAP) |=>
      (x_ff == $past(var_val)) && (mem_ff[idx_ff] == $past(x_ff));
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap did not exchange");

  property p_comp;
    (state_ff == ST_CALC && typ_ff == T_COMP) |=>
      (o_flag_gt == $past(cmp_gt)) && (o_flag_lt == $past(cmp_lt)) &&
      (x_ff == $past(x_ff)) && (mem_ff[idx_ff] == $past(var_val));
  endproperty
  a_comp: assert property (p_comp)
    else $error("compare flags wrong or operand changed");

  property p_reply;
    fin |=> o_done && o_reply_status == STATUS_OK &&
            (o_reply_valid == $past(dir_ff)) ##1 !o_done;
  endproperty
  a_reply: assert property (p_reply)
    else $error("reply missing or wrong status");

  property p_div_zero;
    (state_ff == ST_CALC && (typ_ff == T_DIV || typ_ff == T_MOD) &&
     src == 32'h0000_0000) |=>
      (x_ff == $past(x_ff)) && (mem_ff[idx_ff] == $past(var_val)) &&
      o_done;
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("zero divisor changed destination");

  property p_vi_bad;
    (state_ff == ST_CALC && opc_ff == OPC_VI &&
     (typ_ff == T_SWAP || typ_ff > T_COMP)) |=>
      mem_ff[idx_ff] == $past(var_val) && $stable(flg_ff) && $stable(x_ff);
  endproperty
  a_vi_bad: assert property (p_vi_bad)
    else $error("undefined type changed operand");

  property p_vi_load;
    (state_ff == ST_CALC && opc_ff == OPC_VI && typ_ff == T_LOAD) |=>
      mem_ff[idx_ff] == $past(imm_ff);
  endproperty
  a_vi_load: assert property (p_vi_load)
    else $error("immediate load wrong");

  property p_div_time;
    div_start |-> !o_ready [*8] ##27 o_done;
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("division did not finish in 34 cycles");

  property p_flag_hold;
    !fin |=> $stable(flg_ff);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flags changed without a command");

  c_swap: cover property (state_ff == ST_CALC && typ_ff == T_SWAP);
  c_div:  cover property (div_done && typ_ff == T_MOD);
  c_comp: cover property (cmp && cmp_gt);
  c_rep:  cover property (o_reply_valid);

endmodule
`default_nettype wire
